// ### src/dra_write_core.sv
// display ram with mode-dependent write addressing and cascade gating
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE_01: set-index command loads the write index
// RULE_02: data byte stored at current write index
// RULE_03: static mode advances index by eight
// RULE_04: two-backplane mode advances index by four
// RULE_05: three-backplane mode advances index by three
// RULE_06: four-backplane mode advances index by two
// RULE_07: master reloads index after aborted transfer
// RULE_08: store only when cascade count matches pins
// RULE_09: cascade-select command loads cascade counter
// RULE_10: mismatch suppresses store, index still advances
// RULE_11: index overflow increments cascade counter
// RULE_12: bytes continue across devices, even mid-byte
// RULE_13: system keeps subaddress pins stable during access
// RULE_14: untouched ram bits keep their contents
// RULE_15: static mode places bits in row zero
// RULE_16: three-backplane triples, last row-two bit untouched
// RULE_17: four-backplane places nibbles over two columns
// RULE_18: overflow wraps index to zero, keeps remainder
module dra_write_core
    import dra_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       link_clk,
    input  wire logic       link_valid,
    input  wire logic [1:0] link_kind,
    input  wire logic [7:0] link_byte,
    input  wire logic [1:0] drive_mode,
    input  wire logic       cascade_id_pin_low,
    input  wire logic       cascade_id_pin_high,
    input  wire logic [7:0] rd_addr,
    output logic      [3:0] rd_data,
    output logic      [7:0] write_index,
    output logic      [1:0] cascade_count,
    output logic            busy
);

    typedef enum logic {DRA_IDLE, DRA_WRITE} dra_state_e;

    dra_evt_if ev ();                      // byte events from the crossing

    dra_state_e state_reg;                 // idle or placing columns
    logic [7:0] idx_reg;                   // write index
    logic [1:0] casc_reg;                  // cascade subaddress counter
    logic [3:0] col_reg;                   // column number within a byte
    logic [1:0] mode_reg;                  // drive mode frozen per byte
    logic [7:0] byte_reg;                  // byte being placed
    logic [3:0] ram_reg [RAM_DEPTH];       // display ram, rows in bits
    logic [3:0] rd_data_reg;               // registered read port
    logic       busy_reg;                  // mirrors the write state
    logic [1:0] mode_s1_reg;               // mode pin sync stage one
    logic [1:0] mode_s2_reg;               // mode pin sync stage two
    logic [1:0] sub_s1_reg;                // subaddress pin sync one
    logic [1:0] sub_s2_reg;                // subaddress pin sync two
    logic [3:0] col_bits;                  // data for the current column
    logic [3:0] col_mask;                  // rows written in this column
    logic       match;                     // cascade count equals pins
    logic       col_last;                  // final column of the byte
    logic       take_data;                 // data byte accepted

    dra_link_cross u_cross (
        .link_clk   (link_clk),
        .clk        (clk),
        .nrst       (nrst),
        .link_valid (link_valid),
        .link_kind  (link_kind),
        .link_byte  (link_byte),
        .ev         (ev)
    );

    // pins come from outside the clock domain; the subaddress pins
    // are only sampled here, their stability is the system's duty
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_s1_reg <= MODE_STAT;
            mode_s2_reg <= MODE_STAT;
            sub_s1_reg  <= 2'h0;
            sub_s2_reg  <= 2'h0;
        end else begin
            mode_s1_reg <= drive_mode;
            mode_s2_reg <= mode_s1_reg;
            sub_s1_reg  <= {cascade_id_pin_high, cascade_id_pin_low};
            sub_s2_reg  <= sub_s1_reg;
        end
    end

    // storage gate: counter against the hardware subaddress
    assign match     = (casc_reg == sub_s2_reg);           // RULE_08
    assign col_last  = (col_reg == step_of(mode_reg) - 4'h1);
    // bytes arriving mid-write would be dropped; the link is far slower
    assign take_data = (state_reg == DRA_IDLE) && ev.evt
                       && (ev.kind == KIND_DATA);

    // bit placement: msb first, bits_of rows per column, the tail of
    // a byte may leave high rows of the last column untouched
    always_comb begin
        int base;
        int bit_no;
        base     = 0;
        bit_no   = 0;
        col_bits = COL_RST;
        col_mask = COL_RST;
        base     = 7 - int'(col_reg) * int'(bits_of(mode_reg));
        for (int r = 0; r < ROW_W; r++) begin
            bit_no = base - r;
            if (r < int'(bits_of(mode_reg)) && bit_no >= 0) begin
                col_mask[r] = 1'b1;                     // RULE_15 RULE_17
                col_bits[r] = byte_reg[bit_no[2:0]];    // RULE_16
            end
        end
    end

    // sequencer: one column per cycle, step_of columns per byte
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= DRA_IDLE;
            col_reg   <= 4'h0;
            mode_reg  <= MODE_STAT;
            byte_reg  <= 8'h00;
        end else begin
            case (state_reg)
                DRA_IDLE: begin
                    if (take_data) begin                // RULE_02
                        state_reg <= DRA_WRITE;
                        col_reg   <= 4'h0;
                        mode_reg  <= mode_s2_reg;
                        byte_reg  <= ev.value;
                    end
                end
                DRA_WRITE: begin
                    if (col_last)
                        state_reg <= DRA_IDLE;
                    else
                        col_reg <= col_reg + 4'h1;
                end
                default: state_reg <= DRA_IDLE;
            endcase
        end
    end

    // write index: loaded by command, one column per write cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idx_reg <= IDX_RST;
        end else if (state_reg == DRA_WRITE) begin
            // advance whether stored or not; summed per byte this is
            // the mode's step, with the remainder kept past a wrap
            idx_reg <= wrap_add(idx_reg, 4'h1);   // RULE_10 RULE_18
        end else if (ev.evt && ev.kind == KIND_INDEX
                     && ev.value <= LAST_IDX) begin
            // out-of-range loads are ignored rather than aliased
            idx_reg <= ev.value;                  // RULE_01
        end
    end

    // cascade counter: loaded by command, bumped on index overflow
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            casc_reg <= CASC_RST;
        end else if (state_reg == DRA_WRITE) begin
            if (idx_reg == LAST_IDX)
                casc_reg <= casc_reg + 2'h1;      // RULE_11 RULE_12
        end else if (ev.evt && ev.kind == KIND_CASC) begin
            casc_reg <= ev.value[1:0];            // RULE_09
        end
    end

    // ram: masked column write, gated by the subaddress match
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int c = 0; c < RAM_DEPTH; c++)
                ram_reg[c] <= COL_RST;
        end else if (state_reg == DRA_WRITE && match) begin
            ram_reg[idx_reg] <= (ram_reg[idx_reg] & ~col_mask)
                                | (col_bits & col_mask); // RULE_14
        end
    end

    // registered read port and status
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_reg <= COL_RST;
            busy_reg    <= 1'b0;
        end else begin
            rd_data_reg <= (rd_addr <= LAST_IDX) ? ram_reg[rd_addr]
                                                 : COL_RST;
            busy_reg    <= take_data || (state_reg == DRA_WRITE
                                         && !col_last);
        end
    end

    assign rd_data       = rd_data_reg;
    assign write_index   = idx_reg;
    assign cascade_count = casc_reg;
    assign busy          = busy_reg;

    // assertions: byte placement, index stepping and cascade gating
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // a data byte accepted in a given mode
    sequence s_start(logic [1:0] m);
        take_data && mode_s2_reg == m;
    endsequence

    // one column cycle at the last ram column
    sequence s_at_last;
        state_reg == DRA_WRITE && idx_reg == LAST_IDX;
    endsequence

    // a column cycle placed in a given mode
    sequence s_write(logic [1:0] m);
        state_reg == DRA_WRITE && mode_reg == m;
    endsequence

    AST_LOAD_INDEX: assert property (                          // RULE_01
        (state_reg == DRA_IDLE && ev.evt && ev.kind == KIND_INDEX
         && ev.value <= LAST_IDX) |=> idx_reg == $past(ev.value))
        else $error("write index not loaded by command");

    AST_STEP_STATIC: assert property (                         // RULE_03
        s_start(MODE_STAT) |-> ##9
        idx_reg == wrap_add($past(idx_reg, 9), 4'h8))
        else $error("static step is not eight");

    AST_STEP_MUX2: assert property (                           // RULE_04
        s_start(MODE_MUX2) |-> ##5
        idx_reg == wrap_add($past(idx_reg, 5), 4'h4))
        else $error("two-backplane step is not four");

    AST_STEP_MUX3: assert property (                           // RULE_05
        s_start(MODE_MUX3) |-> ##4
        idx_reg == wrap_add($past(idx_reg, 4), 4'h3))
        else $error("three-backplane step is not three");

    AST_STEP_MUX4: assert property (                           // RULE_06
        s_start(MODE_MUX4) |-> ##3
        idx_reg == wrap_add($past(idx_reg, 3), 4'h2))
        else $error("four-backplane step is not two");

    AST_NO_STORE: assert property (                            // RULE_10
        (state_reg == DRA_WRITE && !match) |=>
        ram_reg[$past(idx_reg)] == $past(ram_reg[idx_reg]))
        else $error("ram written while subaddress mismatched");

    AST_STORE: assert property (                               // RULE_08
        (state_reg == DRA_WRITE && match) |=>
        (ram_reg[$past(idx_reg)] & $past(col_mask))
        == ($past(col_bits) & $past(col_mask)))
        else $error("column data not stored");

    AST_KEEP: assert property (                                // RULE_14
        (state_reg == DRA_WRITE) |=>
        (ram_reg[$past(idx_reg)] & ~$past(col_mask))
        == ($past(ram_reg[idx_reg]) & ~$past(col_mask)))
        else $error("unaddressed ram bits changed");

    AST_OVERFLOW: assert property (                            // RULE_11
        s_at_last |=> idx_reg == 8'h00
        && casc_reg == $past(casc_reg) + 2'h1)
        else $error("overflow did not wrap and bump cascade");

    AST_CASC_LOAD: assert property (                           // RULE_09
        (state_reg == DRA_IDLE && ev.evt && ev.kind == KIND_CASC)
        |=> casc_reg == $past(ev.value[1:0]))
        else $error("cascade counter not loaded");

    AST_MUX3_TAIL: assert property (                           // RULE_16
        (state_reg == DRA_WRITE && mode_reg == MODE_MUX3
         && col_reg == 4'h2) |-> col_mask == 4'h3)
        else $error("third column row two not preserved");

    // busy length equals the step, so a master may pace bytes by it
    AST_BUSY_STATIC: assert property ( // RULE_03
        s_start(MODE_STAT) |=> busy_reg [*8] ##1 !busy_reg)
        else $error("static busy length is not eight");

    AST_BUSY_MUX2: assert property ( // RULE_04
        s_start(MODE_MUX2) |=> busy_reg [*4] ##1 !busy_reg)
        else $error("two-backplane busy length is not four");

    AST_BUSY_MUX3: assert property ( // RULE_05
        s_start(MODE_MUX3) |=> busy_reg [*3] ##1 !busy_reg)
        else $error("three-backplane busy length is not three");

    AST_BUSY_MUX4: assert property ( // RULE_06
        s_start(MODE_MUX4) |=> busy_reg [*2] ##1 !busy_reg)
        else $error("four-backplane busy length is not two");

    // the byte and mode are captured once, at the start of a byte
    AST_FIRST_COL: assert property ( // RULE_02
        take_data |=> state_reg == DRA_WRITE && col_reg == 4'h0
        && byte_reg == $past(ev.value) && mode_reg == $past(mode_s2_reg))
        else $error("data byte not captured for placement");

    // mismatched slots still step, so cascaded parts stay in line
    AST_ADVANCE: assert property ( // RULE_10
        (state_reg == DRA_WRITE) |=>
        idx_reg == wrap_add($past(idx_reg), 4'h1))
        else $error("write index did not advance one column");

    // an idle core with no event must leave the index alone
    AST_IDX_HOLD: assert property ( // RULE_01
        (state_reg == DRA_IDLE && !ev.evt) |=> $stable(idx_reg))
        else $error("write index changed with no cause");

    // during writes the counter moves only at the wrap, never mid-range
    AST_CASC_HOLD: assert property ( // RULE_11
        (state_reg == DRA_WRITE && idx_reg != LAST_IDX)
        |=> $stable(casc_reg))
        else $error("cascade counter moved without overflow");

    // row masks per mode; bits outside the mask keep their contents
    AST_STATIC_ROW0: assert property ( // RULE_15
        s_write(MODE_STAT) |-> col_mask == 4'h1)
        else $error("static mode wrote outside row zero");

    AST_MUX2_ROWS: assert property ( // RULE_14
        s_write(MODE_MUX2) |-> col_mask == 4'h3)
        else $error("two-backplane mode wrote outside rows 0 and 1");

    AST_MUX4_ROWS: assert property ( // RULE_17
        s_write(MODE_MUX4) |-> col_mask == 4'hf)
        else $error("four-backplane mode did not fill four rows");

    // the read port shows the addressed column one cycle later
    AST_RD_PORT: assert property ( // RULE_14
        (rd_addr <= LAST_IDX) |=> rd_data_reg == $past(ram_reg[rd_addr]))
        else $error("read port does not show the addressed column");

    // out-of-range reads return zero rather than an aliased column
    AST_RD_RANGE: assert property ( // RULE_02
        (rd_addr > LAST_IDX) |=> rd_data_reg == COL_RST)
        else $error("read port shows data past the last column");

endmodule // dra_write_core
`default_nettype wire

// ### src/dra_pkg.sv
// shared constants, encodings and helpers for the display ram write path
package dra_pkg;

    // display ram geometry
    localparam int          RAM_DEPTH  = 160;         // columns of the ram
    localparam int          IDX_W      = 8;           // write index width
    localparam int          ROW_W      = 4;           // rows per column
    localparam int          CASC_W     = 2;           // cascade counter width
    localparam logic [7:0]  LAST_IDX   = 8'h9f;       // last column, 159
    localparam logic [7:0]  IDX_RST    = 8'h00;       // write index at reset
    localparam logic [1:0]  CASC_RST   = 2'h0;        // cascade count at reset
    localparam logic [3:0]  COL_RST    = 4'h0;        // ram column at reset

    // byte kinds presented by the link front end
    localparam logic [1:0]  KIND_DATA  = 2'h0;        // display data byte
    localparam logic [1:0]  KIND_INDEX = 2'h1;        // set write index
    localparam logic [1:0]  KIND_CASC  = 2'h2;        // cascade select

    // multiplex drive modes on the mode pins
    localparam logic [1:0]  MODE_STAT  = 2'h0;        // static, one row
    localparam logic [1:0]  MODE_MUX2  = 2'h1;        // two backplanes
    localparam logic [1:0]  MODE_MUX3  = 2'h2;        // three backplanes
    localparam logic [1:0]  MODE_MUX4  = 2'h3;        // four backplanes

    // index advance per data byte, stored or not, one column per cycle
    function automatic logic [3:0] step_of(input logic [1:0] mode);
        case (mode)
            MODE_STAT: step_of = 4'h8; // RULE_03
            MODE_MUX2: step_of = 4'h4; // RULE_04
            MODE_MUX3: step_of = 4'h3; // RULE_05
            default:   step_of = 4'h2; // RULE_06
        endcase
    endfunction

    // data bits placed into one column
    function automatic logic [2:0] bits_of(input logic [1:0] mode);
        bits_of = 3'(mode) + 3'h1;
    endfunction

    // add to the write index, wrapping past the last column
    function automatic logic [7:0] wrap_add(input logic [7:0] idx,
                                            input logic [3:0] n);
        logic [8:0] sum;
        sum = 9'(idx) + 9'(n);
        if (sum > 9'(LAST_IDX))
            wrap_add = 8'(sum - 9'(RAM_DEPTH));
        else
            wrap_add = sum[7:0];
    endfunction

endpackage

// ### src/dra_evt_if.sv
// byte events handed from the link crossing to the ram write core
`timescale 1ns/1ps
`default_nettype none
interface dra_evt_if;
    logic       evt;      // one clk-cycle pulse per received byte
    logic [1:0] kind;     // byte kind, valid with evt
    logic [7:0] value;    // byte value, valid with evt

    modport producer (output evt, output kind, output value);
    modport consumer (input evt, input kind, input value);
endinterface
`default_nettype wire

// ### src/dra_link_cross.sv
// link-clock byte capture and toggle crossing into the core clock
`timescale 1ns/1ps
`default_nettype none
module dra_link_cross
    import dra_pkg::*;
(
    input  wire logic       link_clk,
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       link_valid,
    input  wire logic [1:0] link_kind,
    input  wire logic [7:0] link_byte,
    dra_evt_if.producer     ev
);

    logic       req_tgl_reg;   // flips once per captured byte
    logic [1:0] hold_kind_reg; // held until the next byte
    logic [7:0] hold_byte_reg; // held until the next byte
    logic       sync1_reg;     // first synchroniser stage
    logic       sync2_reg;     // second synchroniser stage
    logic       seen_reg;      // last toggle level consumed
    logic       evt_reg;       // pulse towards the core
    logic [1:0] kind_reg;
    logic [7:0] value_reg;

    // link side: hold the byte, then announce it by a toggle
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            req_tgl_reg   <= 1'b0;
            hold_kind_reg <= KIND_DATA;
            hold_byte_reg <= 8'h00;
        end else if (link_valid) begin
            req_tgl_reg   <= ~req_tgl_reg;
            hold_kind_reg <= link_kind;
            hold_byte_reg <= link_byte;
        end
    end

    // core side: two stages, only the second is looked at
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= req_tgl_reg;
            sync2_reg <= sync1_reg;
        end
    end

    // hold words are stable long before the toggle is seen here
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seen_reg  <= 1'b0;
            evt_reg   <= 1'b0;
            kind_reg  <= KIND_DATA;
            value_reg <= 8'h00;
        end else begin
            seen_reg <= sync2_reg;
            evt_reg  <= sync2_reg ^ seen_reg;
            if (sync2_reg ^ seen_reg) begin
                kind_reg  <= hold_kind_reg;
                value_reg <= hold_byte_reg;
            end
        end
    end

    assign ev.evt   = evt_reg;
    assign ev.kind  = kind_reg;
    assign ev.value = value_reg;

endmodule // dra_link_cross
`default_nettype wire

// ### test/dra_link_master.sv
// link-side byte master model: makes the link clock and sends bytes
`timescale 1ns/1ps
`default_nettype none
module dra_link_master (
    output logic       link_clk,
    output logic       link_valid,
    output logic [1:0] link_kind,
    output logic [7:0] link_byte
);
    // link clock runs only inside send() or idle(); set at declaration so the
    // bench's first idle() cannot be undone by this model's start-up
    logic run = 1'b0;

    // free time base, offset so its phase owes nothing to the core clock
    initial begin
        link_clk   = 1'b0;
        link_valid = 1'b0;
        link_kind  = 2'h3;
        link_byte  = 8'h5a;
        #3.3;
        forever #6 link_clk = run ? ~link_clk : 1'b0;
    end

    // clock the link for n cycles with no byte, e.g. across reset
    task automatic idle(input int n);
        run = 1'b1;
        repeat (n) @(negedge link_clk);
        run = 1'b0;
    endtask

    // one byte: lead-in, one qualified rising edge, then a short tail
    task automatic send(input logic [1:0] kind, input logic [7:0] value,
                        input logic [1:0] extra);
        run = 1'b1;
        repeat (3 + extra) @(negedge link_clk); // slow or prompt master
        link_valid = 1'b1;
        link_kind  = kind;
        link_byte  = value;
        @(negedge link_clk);
        link_valid = 1'b0;
        // released lines show the inverse, never the stale byte
        link_kind  = ~kind;
        link_byte  = ~value;
        repeat (3) @(negedge link_clk);
        run = 1'b0;
    endtask
endmodule // dra_link_master
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the display ram write addressing core
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dra_pkg::*;
    logic       clk, nrst, link_clk, link_valid, busy;
    logic [1:0] link_kind, drive_mode, cascade_count, pins, mode;
    logic [7:0] link_byte, rd_addr, write_index;
    logic [3:0] rd_data;
    logic [3:0] m_ram [0:159]; // expected ram contents
    logic [7:0] m_idx;         // expected write index
    logic [1:0] m_casc;        // expected cascade counter
    logic [1:0] order [4] = '{2'h3, 2'h0, 2'h1, 2'h2};
    logic [9:0] edge_tab [3] = '{{2'h2, 8'h9e}, {2'h0, 8'h9c}, {2'h1, 8'h05}};
    logic [1:0] offs_tab [3] = '{2'h3, 2'h0, 2'h1};
    int         errors, checks_done, cycles;

    dra_write_core dut (.clk(clk), .nrst(nrst), .link_clk(link_clk),
        .link_valid(link_valid), .link_kind(link_kind),
        .link_byte(link_byte), .drive_mode(drive_mode),
        .cascade_id_pin_low(pins[0]), .cascade_id_pin_high(pins[1]),
        .rd_addr(rd_addr), .rd_data(rd_data), .write_index(write_index),
        .cascade_count(cascade_count), .busy(busy));
    dra_link_master mst (.link_clk(link_clk), .link_valid(link_valid),
        .link_kind(link_kind), .link_byte(link_byte));

    // core clock, 8 ns period
    initial clk = 1'b0;
    always #4 clk = ~clk;

    // hang guard, far above the few thousand cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // columns covered by one byte in a given mode
    function automatic int exp_step(input logic [1:0] m);
        return (m == 2'h0) ? 8 : (m == 2'h1) ? 4 : (m == 2'h2) ? 3 : 2;
    endfunction

    // place one byte msb first, row 0 taking the highest remaining bit
    function automatic void model_byte(input logic [7:0] b);
        int nb, k;
        nb = int'(mode) + 1;
        for (int c = 0; c < exp_step(mode); c++) begin
            for (int r = 0; r < nb; r++) begin
                k = c * nb + r;
                // bits past the eighth are left alone, as is a stale slot
                if (k < 8 && m_casc == pins)
                    m_ram[m_idx][r] = b[7 - k];
            end
            if (m_idx == LAST_IDX) begin
                m_idx  = 8'h00;
                m_casc = m_casc + 2'h1;
            end else
                m_idx = m_idx + 8'h01;
        end
    endfunction

    task automatic put_cmd(input logic [1:0] kind, input logic [7:0] v);
        mst.send(kind, v, 2'h0);
        repeat (12) @(negedge clk);
        if (kind == KIND_INDEX && v <= LAST_IDX)
            m_idx = v;
        if (kind == KIND_CASC)
            m_casc = v[1:0];
        check("write_index", write_index, m_idx);
        check("cascade_count", 8'(cascade_count), 8'(m_casc));
    endtask

    task automatic put_data(input logic [7:0] b);
        int n, hi;
        n  = 0;
        hi = 0;
        fork
            mst.send(KIND_DATA, b, 2'($urandom_range(3)));
            begin
                while (busy !== 1'b1 && n < 40) begin
                    @(negedge clk);
                    n++;
                end
                while (busy === 1'b1 && hi < 20) begin
                    @(negedge clk);
                    hi++;
                end
            end
        join
        repeat (4) @(negedge clk);
        model_byte(b);
        check("busy", 8'(hi), 8'(exp_step(mode)));
        check("write_index", write_index, m_idx);
        check("cascade_count", 8'(cascade_count), 8'(m_casc));
    endtask

    // read every column plus one past the end
    task automatic check_ram();
        for (int a = 0; a < 161; a++) begin
            @(negedge clk);
            rd_addr = 8'(a);
            @(negedge clk);
            check("rd_data", {4'h0, rd_data},
                  (a < 160) ? {4'h0, m_ram[a]} : 8'h00);
        end
    endtask

    // new pins and mode only between accesses, then let the syncs settle
    task automatic set_pins(input logic [1:0] m);
        @(negedge clk);
        pins       = 2'($urandom);
        drive_mode = m;
        mode       = m;
        repeat (4) @(negedge clk);
    endtask

    initial begin
        void'($urandom(32'hf1a69d33));
        nrst = 1'b0;
        drive_mode = MODE_STAT;
        mode = MODE_STAT;
        pins = 2'h0;
        rd_addr = 8'h00;
        m_idx = IDX_RST;
        m_casc = CASC_RST;
        foreach (m_ram[i])
            m_ram[i] = COL_RST;
        fork
            mst.idle(4);
            repeat (10) @(posedge clk);
        join
        @(negedge clk);
        nrst = 1'b1;
        check("busy", 8'(busy), 8'h00);
        check_ram();
        $display("test reset values done");
        // each mode over shared columns, first byte all ones
        foreach (order[i]) begin
            set_pins(order[i]);
            put_cmd(KIND_INDEX, 8'h10);
            put_cmd(KIND_CASC, 8'(pins));
            for (int j = 0; j < 4; j++)
                put_data((j == 0) ? 8'hff : 8'($urandom));
            check_ram();
            $display("test mode %0d done", order[i]);
        end
        // slot mismatch and wrap into the next slot, also mid-byte
        foreach (edge_tab[i]) begin
            set_pins(edge_tab[i][9:8]);
            put_cmd(KIND_INDEX, edge_tab[i][7:0]);
            put_cmd(KIND_CASC, 8'(pins + offs_tab[i]));
            for (int j = 0; j < 3; j++)
                put_data(8'($urandom));
            check_ram();
            $display("test cascade case %0d done", i);
        end
        // refused loads: index past the end, unused kind
        put_cmd(KIND_INDEX, 8'ha0);
        put_cmd(2'h3, 8'h55);
        $display("test refused commands done");
        final_report();
    end
endmodule // tb
`default_nettype wire
